// ---- src/crs_defs.svh ----
// Constants for the core regulator sequencer
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

`define CRS_CODE_W 5
`define CRS_CODE_OFF 5'h1f
`define CRS_CNT_W 11
`define CRS_SS_LAST 11'h7ff
`define CRS_OC_WAIT_LAST 11'h7ff
`define CRS_MV_W 12
`define CRS_REF_TOP_MV 12'h73a
`define CRS_STEP_MV 12'h019
`define CRS_RAMP_NUM 32'h0000000e
`define CRS_RAMP_DEN 32'h00005000
`define CRS_RAMP_OFFSET_CURRENT_W 8
`define CRS_RAMP_OFFSET_CURRENT_MAX_UA 32'h000000a0
`define CRS_SS_SHIFT 11
`define CRS_RST_CODE 5'h1f

`endif

// ---- src/crs_pkg.sv ----
// Types for the core regulator sequencer
package crs_pkg;

  typedef enum logic [2:0] {
    CRS_OFF     = 3'b000,
    CRS_SOFT    = 3'b001,
    CRS_RUN     = 3'b010,
    CRS_OC_WAIT = 3'b011,
    CRS_OV_HOLD = 3'b100
  } crs_state_t;

  typedef struct packed {
    crs_state_t st;
    logic [10:0] ss_cnt;
    logic [10:0] oc_cnt;
    logic tick_prev;
    logic [4:0] samp_code;
    logic [4:0] stable_code;
    logic [4:0] ref_idx;
    logic step_ph;
    logic ov_low;
    logic drive_en;
    logic force_low;
    logic run;
    logic [11:0] ref_mv;
    logic [11:0] ramp_mv;
    logic [7:0] ramp_offset_current;
    logic [11:0] target;
  } crs_core_st_t;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } crs_sync_st_t;

endpackage

// ---- src/crs_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module crs_sync (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [5:0] i_async,
  output logic [5:0] o_sync
);
  crs_pkg::crs_sync_st_t q, d;

  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // First stage feeds only the second
  assign o_sync = q.s2;
endmodule // crs_sync

// ---- src/crs_core.sv ----
// Sequencing and protection for a multi-phase core regulator
// What this block does
// RQ1 - Overcurrent at any time shuts converter down
// RQ2 - Overcurrent: PWM hi-Z for 2048 cycles
// RQ3 - Wait done launches soft-start, success continues
// RQ4 - Failed retry repeats wait, indefinitely
// RQ5 - Decode code: 11110=1.100, 00000=1.850, 25mV
// RQ6 - All-ones code shuts down, others restart
// RQ7 - Overvoltage drives all PWM outputs low
// RQ8 - At selected level go hi-Z, recur low
// RQ9 - Overvoltage latched until supply power cycle
// RQ10 - Supply below threshold holds PWM hi-Z
// RQ11 - Supply, enable, valid code start soft-start
// RQ12 - 11-bit counter times 2048-cycle soft-start
// RQ13 - Ramp rises to 140 percent, current falls
// RQ14 - Regulate to lower of reference, ramp
// RQ15 - Sample code only at cycle start; the code also loads it on leaving OFF, with no cycle start
// RQ16 - Stable code steps 25mV per two cycles
// RQ17 - Cycle starts when channel one commanded low
// RQ18 - Overcurrent during soft-start fails the attempt
// RQ19 - Stable means equal at two cycle starts
`timescale 1ns/100ps
`include "crs_defs.svh"
module crs_core (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_supply_ok,
  input wire logic i_enable_ok,
  input wire logic i_overcurrent,
  input wire logic i_overvoltage,
  input wire logic i_vout_at_ref,
  input wire logic i_ch1_cycle_start,
  input wire logic [4:0] i_voltage_select_code,
  output logic o_pwm_drive_en,
  output logic o_pwm_force_low,
  output logic o_pwm_run,
  output logic [11:0] o_reference_level,
  output logic [11:0] o_soft_ramp_voltage,
  output logic [7:0] o_ramp_offset_current,
  output logic [11:0] o_regulation_target,
  output logic [2:0] o_state
);
  crs_pkg::crs_core_st_t q, d;
  logic [5:0] flags_s;
  logic [4:0] code_s;
  logic supply_s;
  logic enable_s;
  logic oc_s;
  logic ov_s;
  logic at_ref_s;
  logic tick_s;
  logic tick;
  logic go_ok;
  logic [31:0] ramp_w;
  logic [31:0] ramp_offset_current_w;
  logic code_pad_unused;

  // Pins cross into the clock domain here
  crs_sync u_flag_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_supply_ok, i_enable_ok, i_overcurrent, i_overvoltage, i_vout_at_ref,
      i_ch1_cycle_start}),
    .o_sync(flags_s)
  );

  // Code bus may skew between bits; stability check absorbs it
  crs_sync u_code_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({1'b0, i_voltage_select_code}),
    .o_sync({code_pad_unused, code_s})
  );

  assign supply_s = flags_s[5];
  assign enable_s = flags_s[4];
  assign oc_s = flags_s[3];
  assign ov_s = flags_s[2];
  assign at_ref_s = flags_s[1];
  assign tick_s = flags_s[0];

  // RQ17 cycle start edge
  assign tick = tick_s & ~q.tick_prev;

  // RQ11 start conditions
  assign go_ok = supply_s & enable_s & (code_s != `CRS_CODE_OFF);

  always_comb begin
    ramp_w = 32'h0;
    ramp_offset_current_w = 32'h0;
    d = q;
    d.tick_prev = tick_s;
    // RQ15 sample at cycle start only
    if (tick) begin
      d.samp_code = code_s;
      // RQ19 equal at two starts
      if (code_s == q.samp_code) begin
        d.stable_code = code_s;
      end
    end
    if (!supply_s) begin
      // RQ10 below supply threshold
      d.st = crs_pkg::CRS_OFF;
      // RQ9 power cycle clears latch
      d.ov_low = 1'b0;
    end else if (ov_s || q.st == crs_pkg::CRS_OV_HOLD) begin
      // RQ9 latched until supply drops
      d.st = crs_pkg::CRS_OV_HOLD;
      // RQ7 drive low on overvoltage
      if (ov_s) begin
        d.ov_low = 1'b1;
      // RQ8 release to hi-Z at level
      end else if (at_ref_s) begin
        d.ov_low = 1'b0;
      end
    end else if (!go_ok) begin
      // RQ6 all-ones code shuts down
      d.st = crs_pkg::CRS_OFF;
    end else begin
      case (q.st)
        crs_pkg::CRS_OFF: begin
          // RQ11 immediate soft-start
          d.st = crs_pkg::CRS_SOFT;
          d.ss_cnt = '0;
          d.ref_idx = code_s;
          d.samp_code = code_s;
          d.stable_code = code_s;
        end
        crs_pkg::CRS_SOFT: begin
          if (oc_s) begin
            // RQ18 soft-start failed
            d.st = crs_pkg::CRS_OC_WAIT;
            d.oc_cnt = '0;
          end else if (tick) begin
            // RQ12 count phase clock pulses
            d.ss_cnt = q.ss_cnt + 11'h001;
            if (q.ss_cnt == `CRS_SS_LAST) begin
              // RQ3 attempt succeeded
              d.st = crs_pkg::CRS_RUN;
              d.step_ph = 1'b0;
            end
          end
        end
        crs_pkg::CRS_RUN: begin
          if (oc_s) begin
            // RQ1 overcurrent shutdown
            d.st = crs_pkg::CRS_OC_WAIT;
            d.oc_cnt = '0;
          end else if (tick && q.ref_idx != q.stable_code &&
              q.stable_code != `CRS_CODE_OFF) begin
            // RQ16 one 25mV step per two cycles
            d.step_ph = ~q.step_ph;
            if (q.step_ph) begin
              if (q.stable_code > q.ref_idx) begin
                d.ref_idx = q.ref_idx + 5'h01;
              end else begin
                d.ref_idx = q.ref_idx - 5'h01;
              end
            end
          end else if (tick) begin
            d.step_ph = 1'b0;
          end
        end
        crs_pkg::CRS_OC_WAIT: begin
          // RQ2 count 2048 cycles in hi-Z
          if (tick) begin
            d.oc_cnt = q.oc_cnt + 11'h001;
            if (q.oc_cnt == `CRS_OC_WAIT_LAST) begin
              // RQ4 retry after each wait
              d.st = crs_pkg::CRS_SOFT;
              d.ss_cnt = '0;
            end
          end
        end
        default: begin
          d.st = crs_pkg::CRS_OFF;
        end
      endcase
    end
    // RQ5 decode to millivolts
    d.ref_mv = 12'(`CRS_REF_TOP_MV - 12'(d.ref_idx) * `CRS_STEP_MV);
    // RQ13 ramp to 140 percent of reference
    if (d.st == crs_pkg::CRS_SOFT) begin
      ramp_w = (32'(d.ref_mv) * `CRS_RAMP_NUM * 32'(d.ss_cnt)) / `CRS_RAMP_DEN;
      ramp_offset_current_w = (`CRS_RAMP_OFFSET_CURRENT_MAX_UA * (32'h00000800 - 32'(d.ss_cnt))) >> `CRS_SS_SHIFT;
    end
    d.ramp_mv = ramp_w[11:0];
    d.ramp_offset_current = ramp_offset_current_w[7:0];
    // RQ14 lower of reference and ramp
    if (d.st == crs_pkg::CRS_SOFT && d.ramp_mv < d.ref_mv) begin
      d.target = d.ramp_mv;
    end else begin
      d.target = d.ref_mv;
    end
    // Pin state: hi-Z unless soft-start, run or overvoltage pull-down
    d.run = (d.st == crs_pkg::CRS_SOFT) || (d.st == crs_pkg::CRS_RUN);
    d.force_low = (d.st == crs_pkg::CRS_OV_HOLD) && d.ov_low;
    d.drive_en = d.run || d.force_low;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Reference shows the code 00000 level so decode holds from release
      q <= '{st: crs_pkg::CRS_OFF, samp_code: `CRS_RST_CODE,
        stable_code: `CRS_RST_CODE, ref_mv: `CRS_REF_TOP_MV,
        target: `CRS_REF_TOP_MV, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_pwm_drive_en = q.drive_en;
  assign o_pwm_force_low = q.force_low;
  assign o_pwm_run = q.run;
  assign o_reference_level = q.ref_mv;
  assign o_soft_ramp_voltage = q.ramp_mv;
  assign o_ramp_offset_current = q.ramp_offset_current;
  assign o_regulation_target = q.target;
  assign o_state = q.st;

  a_oc_run_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ1
    q.st == crs_pkg::CRS_RUN && oc_s && go_ok && !ov_s |=> q.st == crs_pkg::CRS_OC_WAIT)
    else $error("overcurrent did not stop regulation");

  a_wait_hiz: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ2
    q.st == crs_pkg::CRS_OC_WAIT |-> !o_pwm_drive_en && !o_pwm_run)
    else $error("pwm driven during overcurrent wait");

  a_wait_retry: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ3
    q.st == crs_pkg::CRS_OC_WAIT && tick && q.oc_cnt == `CRS_OC_WAIT_LAST && go_ok && !ov_s
    |=> q.st == crs_pkg::CRS_SOFT && q.ss_cnt == 11'h000)
    else $error("no soft-start after wait");

  a_wait_early: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ4
    q.st == crs_pkg::CRS_OC_WAIT && q.oc_cnt != `CRS_OC_WAIT_LAST && go_ok && !ov_s
    |=> q.st == crs_pkg::CRS_OC_WAIT)
    else $error("wait ended early");

  a_soft_fail: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ18
    q.st == crs_pkg::CRS_SOFT && oc_s && go_ok && !ov_s
    |=> q.st == crs_pkg::CRS_OC_WAIT && q.oc_cnt == 11'h000)
    else $error("soft-start failure not caught");

  a_ref_decode: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ5
    o_reference_level == 12'(12'h73a - 12'(q.ref_idx) * 12'h019))
    else $error("reference decode wrong");

  a_off_code: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ6
    supply_s && !ov_s && q.st != crs_pkg::CRS_OV_HOLD && code_s == 5'h1f
    |=> q.st == crs_pkg::CRS_OFF && !o_pwm_drive_en)
    else $error("shutdown code ignored");

  a_ov_pull_low: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ7
    supply_s && ov_s |=> o_pwm_drive_en && o_pwm_force_low && !o_pwm_run)
    else $error("overvoltage did not pull low");

  a_ov_release: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ8
    q.st == crs_pkg::CRS_OV_HOLD && supply_s && !ov_s && at_ref_s |=> !o_pwm_drive_en)
    else $error("overvoltage did not release to hi-Z");

  a_ov_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ9
    q.st == crs_pkg::CRS_OV_HOLD && supply_s |=> q.st == crs_pkg::CRS_OV_HOLD)
    else $error("overvoltage latch lost");

  a_supply_hiz: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ10
    !supply_s |=> !o_pwm_drive_en && q.st == crs_pkg::CRS_OFF)
    else $error("pwm driven without supply");

  a_start_now: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ11
    q.st == crs_pkg::CRS_OFF && go_ok && !ov_s |=> q.st == crs_pkg::CRS_SOFT && o_pwm_run)
    else $error("soft-start not started");

  a_target_min: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ14
    o_regulation_target <= o_reference_level &&
    (q.st != crs_pkg::CRS_SOFT || o_regulation_target <= o_soft_ramp_voltage))
    else $error("target above lower bound");

  a_step_size: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ16
    q.st == crs_pkg::CRS_RUN && $past(q.st) == crs_pkg::CRS_RUN && $changed(q.ref_idx)
    |-> (q.ref_idx == $past(q.ref_idx) + 5'h01 || q.ref_idx == $past(q.ref_idx) - 5'h01)
    ##1 $stable(q.ref_idx))
    else $error("reference step wrong");

  // RQ12 count on tick
  a_ss_advance: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ12
    q.st == crs_pkg::CRS_SOFT && tick && !oc_s && go_ok && !ov_s
    |=> q.ss_cnt == $past(q.ss_cnt) + 11'h001)
    else $error("soft-start count missed a cycle");

  // RQ12 hold between ticks
  a_ss_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ12
    q.st == crs_pkg::CRS_SOFT && !tick && !oc_s && go_ok && !ov_s
    |=> q.st == crs_pkg::CRS_SOFT && $stable(q.ss_cnt))
    else $error("soft-start count moved off cycle start");

  // RQ2 wait counts ticks
  a_oc_count: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ2
    q.st == crs_pkg::CRS_OC_WAIT && tick && go_ok && !ov_s
    |=> q.oc_cnt == $past(q.oc_cnt) + 11'h001)
    else $error("overcurrent wait count missed a cycle");

  // RQ5 level inside table
  a_ref_range: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ5
    q.st == crs_pkg::CRS_SOFT || q.st == crs_pkg::CRS_RUN
    |-> o_reference_level >= 12'h44c && o_reference_level <= 12'h73a)
    else $error("reference outside code table");

  // RQ13 ramp starts low
  a_ramp_start: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ13
    q.st == crs_pkg::CRS_SOFT && q.ss_cnt == 11'h000
    |-> o_soft_ramp_voltage == 12'h000 && o_ramp_offset_current == 8'ha0)
    else $error("soft-start ramp did not start at zero");

  // RQ13 ramp ends near 140 percent
  a_ramp_peak: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ13
    q.st == crs_pkg::CRS_SOFT && q.ss_cnt == `CRS_SS_LAST
    |-> o_ramp_offset_current == 8'h00 &&
    {4'h0, o_soft_ramp_voltage} * 16'h000a >= {4'h0, o_reference_level} * 16'h000d &&
    {4'h0, o_soft_ramp_voltage} * 16'h000a <= {4'h0, o_reference_level} * 16'h000e)
    else $error("soft-start ramp end wrong");

  // RQ15 code taken at start
  a_code_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ15
    !tick && q.st != crs_pkg::CRS_OFF |=> $stable(q.samp_code))
    else $error("code sampled off cycle start");

  // RQ19 mismatch keeps target
  a_stable_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ19
    tick && code_s != q.samp_code && q.st != crs_pkg::CRS_OFF
    |=> $stable(q.stable_code))
    else $error("code taken before it was stable");

  // RQ16 no step on odd cycle
  a_step_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ16
    q.st == crs_pkg::CRS_RUN && tick && !q.step_ph && !oc_s && go_ok && !ov_s
    |=> $stable(q.ref_idx))
    else $error("reference stepped on consecutive cycles");

  c_hiccup: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    q.st == crs_pkg::CRS_OC_WAIT ##1 q.st == crs_pkg::CRS_SOFT);
  c_soft_done: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    q.st == crs_pkg::CRS_SOFT ##1 q.st == crs_pkg::CRS_RUN);
  c_ov_cycle: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pwm_force_low ##1 !o_pwm_force_low && q.st == crs_pkg::CRS_OV_HOLD);
  c_dyn_step: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    q.st == crs_pkg::CRS_RUN && $changed(q.ref_idx));
endmodule // crs_core

// ---- sim/crs_drv_model.sv ----
// Phase clock source and gate-driver view of the PWM controls
`timescale 1ns/100ps
module crs_drv_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_drive_en,
  input wire logic i_force_low,
  output logic o_cycle_start,
  output logic [1:0] o_drv_mode
);
  logic [2:0] cnt_q = 3'h0;
  // Slow mode doubles the switching cycle
  always @(posedge i_clk) begin
    cnt_q <= cnt_q + 3'h1;
    if (!i_slow && cnt_q[1:0] == 2'h3) cnt_q <= 3'h0;
  end
  // Square wave, so each cycle start survives the input synchroniser
  assign o_cycle_start = i_slow ? cnt_q[2] : cnt_q[1];
  // Driver reading: 0 both switches off, 1 lower on, 2 switching
  assign o_drv_mode = !i_drive_en ? 2'h0 : (i_force_low ? 2'h1 : 2'h2);
endmodule // crs_drv_model

// ---- sim/crs_core_tb.sv ----
// Self-checking bench for the core regulator sequencer
`timescale 1ns/100ps
module crs_core_tb;
  typedef struct packed {
    logic [4:0] code;
    logic sup;
    logic en;
    logic [2:0] st;
  } crs_row_t;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic sup = 1'b0, en = 1'b0, oc = 1'b0, ov = 1'b0, at_ref = 1'b0, slow = 1'b0;
  logic [4:0] code = 5'h0f;
  logic cs, drv_en, frc_low, run;
  logic [1:0] mode;
  logic [11:0] ref_mv, ramp, target;
  logic [7:0] ramp_offset_current;
  logic [2:0] st;
  int errors = 0, n_tests = 0, k;
  // Last row leaves the block in soft-start for the next test
  crs_row_t rows [6] = '{'{5'h1f, 1'b1, 1'b1, 3'h0}, '{5'h0f, 1'b0, 1'b1, 3'h0},
    '{5'h0f, 1'b1, 1'b0, 3'h0}, '{5'h1e, 1'b1, 1'b1, 3'h1}, '{5'h00, 1'b1, 1'b1, 3'h1},
    '{5'h0f, 1'b1, 1'b1, 3'h1}};
  always #4 i_clk = ~i_clk;
  crs_core dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_supply_ok(sup), .i_enable_ok(en),
    .i_overcurrent(oc), .i_overvoltage(ov), .i_vout_at_ref(at_ref), .i_ch1_cycle_start(cs),
    .i_voltage_select_code(code), .o_pwm_drive_en(drv_en), .o_pwm_force_low(frc_low),
    .o_pwm_run(run), .o_reference_level(ref_mv), .o_soft_ramp_voltage(ramp),
    .o_ramp_offset_current(ramp_offset_current), .o_regulation_target(target), .o_state(st));
  crs_drv_model part_u (.i_clk(i_clk), .i_slow(slow), .i_drive_en(drv_en),
    .i_force_low(frc_low), .o_cycle_start(cs), .o_drv_mode(mode));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %0d exp %0d", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Bounded wait on state (sel 0) or reference (sel 1); k holds cycles spent
  task automatic wait_eq(input int sel, input logic [11:0] v, input int lim);
    k = 0;
    while ((sel ? ref_mv : {9'h0, st}) !== v && k < lim) begin
      cyc(1);
      k++;
    end
    if ((sel ? ref_mv : {9'h0, st}) !== v) begin
      errors++;
      $display("BAD t=%0t wait ran out", $time);
      end_of_test();
    end
  endtask
  initial begin
    cyc(16);
    i_sys_rst = 1'b0;
    cyc(1);
    chk(st, 3'h0); // off after reset
    chk(drv_en, 1'b0); // pins released
    foreach (rows[i]) begin
      sup = rows[i].sup;
      en = rows[i].en;
      code = rows[i].code;
      i_sys_rst = 1'b1;
      cyc(3);
      i_sys_rst = 1'b0;
      cyc(3);
      chk(st, rows[i].st);
      chk(mode, rows[i].st == 3'h1 ? 2'h2 : 2'h0);
      if (rows[i].st == 3'h1) begin
        chk(ref_mv, 12'h73a - 12'h019 * rows[i].code);
        chk(ramp_offset_current, 8'ha0);
        chk(ramp, 12'h000);
        chk(run, 1'b1);
      end
    end
    chk(target < ref_mv, 1'b1);
    wait_eq(0, 12'h002, 9000);
    chk(k > 8150 && k < 8200, 1'b1);
    chk(ramp, 12'h000);
    chk(ramp_offset_current, 8'h00);
    chk(target, 12'h5c3);
    // Slow cycles make the two-cycle step spacing easy to see
    slow = 1'b1;
    code = 5'h0d;
    wait_eq(1, 12'h5dc, 200);
    wait_eq(1, 12'h5f5, 40);
    chk(k > 12 && k < 20, 1'b1);
    slow = 1'b0;
    oc = 1'b1;
    cyc(4);
    chk(st, 3'h3);
    chk(mode, 2'h0);
    wait_eq(0, 12'h001, 8300);
    chk(k > 8150 && k < 8200, 1'b1);
    cyc(2);
    chk(st, 3'h3);
    oc = 1'b0;
    wait_eq(0, 12'h001, 8300);
    wait_eq(0, 12'h002, 8300);
    ov = 1'b1;
    cyc(4);
    chk(st, 3'h4);
    chk(mode, 2'h1);
    ov = 1'b0;
    at_ref = 1'b1;
    cyc(4);
    chk(mode, 2'h0);
    at_ref = 1'b0;
    ov = 1'b1;
    cyc(4);
    chk(mode, 2'h1);
    ov = 1'b0;
    en = 1'b0;
    code = 5'h1f;
    cyc(6);
    chk(st, 3'h4);
    sup = 1'b0;
    cyc(4);
    chk({st, mode}, 5'h00);
    sup = 1'b1;
    en = 1'b1;
    code = 5'h1e;
    cyc(5);
    chk(st, 3'h1);
    end_of_test();
  end
endmodule // crs_core_tb
